// ---- rtl/ssf_pkg.sv ----
/*
  Shared definitions of the synchronous serial frame engine: widths, pin and
  configuration carriers, state encoding and the fixed constants of the shifter.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
package ssf_pkg;

  // ----------------------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------------------
  localparam int SSF_DATA_W = 16;
  localparam int SSF_FIFO_DEPTH = 16;
  localparam int SSF_CNT_W = 16;

  // ----------------------------------------------------------------------------
  // Field values and fixed positions
  // ----------------------------------------------------------------------------
  localparam logic SSF_FMT_PULSED = 1'h0;
  localparam logic SSF_FMT_SPI = 1'h1;
  localparam logic [3:0] SSF_SIZE_MIN_M1 = 4'h3;
  localparam logic [3:0] SSF_MSB = 4'hf;
  localparam logic [6:0] SSF_PRE_HALF_MIN = 7'h01;
  localparam logic [15:0] SSF_ONE = 16'h0001;

  // ----------------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic master;
    logic format;
    logic clock_polarity_bit;
    logic clock_phase_bit;
    logic [3:0] size_m1;
    logic [7:0] prescale_divisor;
    logic [7:0] clock_rate_field;
  } ssf_cfg_s;

  typedef struct packed {
    logic serial_clock_pin;
    logic serial_clock_oe_n;
    logic frame_select_pin;
    logic frame_select_oe_n;
    logic serial_out_pin;
    logic serial_out_oe_n;
  } ssf_pins_s;

  typedef enum logic [2:0] {
    SSF_IDLE = 3'b000,
    SSF_PULSE = 3'b001,
    SSF_LEAD = 3'b010,
    SSF_BITS = 3'b011,
    SSF_TAIL = 3'b100,
    SSF_HOLD = 3'b101,
    SSF_GAP = 3'b110
  } ssf_state_e;

endpackage : ssf_pkg

// ---- rtl/ssf_fifo.sv ----
/*
  Synchronous first-in first-out buffer with valid and ready on both sides.
  Assumes a single clock, a synchronous active-low reset and a clock enable
  that freezes every register while it is low.
*/
`timescale 1ns/1ps
module ssf_fifo
  import ssf_pkg::*;
#(
  parameter int WIDTH = SSF_DATA_W,
  parameter int DEPTH = SSF_FIFO_DEPTH
) (
  // Clock, reset and enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire do_wr = clk_en & in_valid & in_ready;
  wire do_rd = clk_en & out_valid & out_ready;

  assign in_ready = count != FULL;
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : ssf_fifo

// ---- rtl/ssf_frame_engine.sv ----
/*
  Frame engine of a synchronous serial port: pulsed-frame and four-mode SPI
  sequencing of serial clock, frame select and data, with a transmit FIFO and a
  receive FIFO between the word streams and the shifter.
  Assumes configuration is changed only while the port is disabled, and that
  the serial input pin is asynchronous to core_clk.
*/
// Contract
// - Pulsed format idle: clock and frame select low, serial output released.
// - Pulsed format: frame select high one clock period; word loaded into shifter.
// - Pulsed format: MSB driven on the rising clock edge after the pulse.
// - Pulsed format: incoming bits sampled on falling clock edges.
// - Pulsed format: received word passed to receive FIFO after LSB sampled.
// - SPI: polarity bit sets the idle clock level, low for 0, high for 1.
// - SPI: phase 0 samples on first clock transition, phase 1 on second.
// - SPI idle: frame select high and serial output driven low.
// - SPI idle: clock driver enabled as master, disabled as slave.
// - SPI: enabled with data queued, master drops frame select, enables output.
// - SPI phase 0: first bit half period after select falls, edge half later.
// - SPI polarity 0 phase 0: sample rising, change falling.
// - SPI phase 0: frame select pulsed high between back-to-back words.
// - SPI phase 0: frame select high one clock period after the last bit is sampled.
// - SPI phase 1: first bits and first clock edge half period after select falls.
// - SPI polarity 0 phase 1: sample falling, change rising.
// - SPI phase 1: frame select stays low between back-to-back words.
// - SPI polarity 1 phase 0: sample falling, change rising.
// - SPI polarity 1 phase 1: sample rising, change falling.
// - Frames are 4 to 16 bits, most significant bit first.
// - Clock stays idle between words, toggles only during transfers.
// - Master clock is core clock over even prescale times one plus rate.
`timescale 1ns/1ps
module ssf_frame_engine
  import ssf_pkg::*;
#(
  parameter int FIFO_DEPTH = SSF_FIFO_DEPTH
) (
  // Clock, reset and enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Configuration
  input wire ssf_cfg_s cfg,
  // Transmit word stream
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [SSF_DATA_W-1:0] tx_data,
  // Receive word stream
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [SSF_DATA_W-1:0] rx_data,
  // Serial pins
  output ssf_pins_s pins,
  input wire logic serial_in_pin,
  // Status
  output logic busy
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  ssf_state_e st;
  logic half;
  logic [3:0] bit_cnt;
  logic [SSF_CNT_W-1:0] cnt;
  logic [SSF_DATA_W-1:0] shift_tx;
  logic [SSF_DATA_W-1:0] shift_rx;
  logic sck;
  logic sck_oe_n;
  logic fss;
  logic fss_oe_n;
  logic sdo;
  logic sdo_oe_n;
  logic in_meta;
  logic in_sync;

  // ----------------------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------------------
  logic txf_valid;
  logic txf_ready;
  logic [SSF_DATA_W-1:0] txf_data;
  logic rxf_valid;
  logic rxf_ready;

  ssf_fifo #(
    .WIDTH(SSF_DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(txf_valid),
    .out_ready(txf_ready),
    .out_data(txf_data)
  );

  // The engine parks in the hold state until the receive FIFO has room, so a
  // stalled reader stops the link rather than losing words.
  ssf_fifo #(
    .WIDTH(SSF_DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .in_valid(rxf_valid),
    .in_ready(rxf_ready),
    .in_data(shift_rx),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // ----------------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------------
  wire spi = cfg.format == SSF_FMT_SPI;
  // Phase 0 samples on the leading edge; phase 1 and the pulsed format on the
  // trailing edge, so both share one bit loop.
  wire samp_lead = spi & ~cfg.clock_phase_bit;
  wire idle_lvl = spi & cfg.clock_polarity_bit;
  wire act_lvl = ~idle_lvl;
  wire [3:0] size_eff = (cfg.size_m1 < SSF_SIZE_MIN_M1) ? SSF_SIZE_MIN_M1 : cfg.size_m1;
  wire [3:0] pad = SSF_MSB - size_eff;
  wire last_bit = bit_cnt == size_eff;
  wire go = cfg.enable & cfg.master & txf_valid;

  // Half-period divider: the prescale is even, so half of it times 1 + rate.
  wire [6:0] pre_half_raw = cfg.prescale_divisor[7:1];
  wire [6:0] pre_half = (pre_half_raw == '0) ? SSF_PRE_HALF_MIN : pre_half_raw;
  wire [SSF_CNT_W-1:0] half_len = SSF_CNT_W'(pre_half) * (SSF_CNT_W'(cfg.clock_rate_field) + SSF_ONE);
  wire [SSF_CNT_W-1:0] half_m1 = half_len - SSF_ONE;
  wire tick = cnt == '0;

  wire in_idle = st == SSF_IDLE;
  wire in_hold = st == SSF_HOLD;
  wire in_bits = st == SSF_BITS;
  wire load_now = (in_idle & go) | (in_hold & rxf_ready & go);
  assign txf_ready = load_now;
  assign rxf_valid = in_hold;

  // Events that move data, each at a half-period boundary.
  wire lead_done = st == SSF_LEAD && (!samp_lead || half);
  wire ev_lead = tick & ((in_bits & half & ~last_bit) | lead_done | (st == SSF_PULSE && half));
  wire ev_trail = tick & in_bits & ~half;
  wire ev_sample = samp_lead ? ev_lead : ev_trail;
  wire ev_first = samp_lead ? (tick & st == SSF_LEAD & ~half) : (ev_lead & ~in_bits);
  wire ev_next = samp_lead ? (ev_trail & ~last_bit) : (ev_lead & in_bits);

  assign busy = ~in_idle;

  // ----------------------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------------------
  assign pins = '{
    serial_clock_pin: sck,
    serial_clock_oe_n: sck_oe_n,
    frame_select_pin: fss,
    frame_select_oe_n: fss_oe_n,
    serial_out_pin: sdo,
    serial_out_oe_n: sdo_oe_n
  };

  // ----------------------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      in_meta <= 1'b0;
      in_sync <= 1'b0;
    end else if (clk_en) begin
      in_meta <= serial_in_pin;
      in_sync <= in_meta;
    end
  end

  // ----------------------------------------------------------------------------
  // Half-period counter
  // ----------------------------------------------------------------------------
  // Restarted whenever the engine waits, so every half after a start is full.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt <= '0;
    end else if (clk_en) begin
      cnt <= (in_idle || in_hold || tick) ? half_m1 : cnt - SSF_ONE;
    end
  end

  // ----------------------------------------------------------------------------
  // Shifters
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      shift_tx <= '0;
      shift_rx <= '0;
      bit_cnt <= '0;
      sdo <= 1'b0;
    end else if (clk_en) begin
      if (load_now) begin
        shift_tx <= txf_data << pad;
        shift_rx <= '0;
        bit_cnt <= '0;
      end else if (ev_next) begin
        shift_tx <= shift_tx << 1;
      end
      if (in_idle) begin
        sdo <= 1'b0;
      end else if (ev_first) begin
        sdo <= shift_tx[SSF_MSB];
      end else if (ev_next) begin
        sdo <= shift_tx[SSF_MSB-1];
      end
      if (ev_sample) begin
        shift_rx <= {shift_rx[SSF_DATA_W-2:0], in_sync};
      end
      if (ev_lead & in_bits) begin
        bit_cnt <= bit_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st <= SSF_IDLE;
      half <= 1'b0;
      sck <= 1'b0;
      sck_oe_n <= 1'b1;
      fss <= 1'b1;
      fss_oe_n <= 1'b1;
      sdo_oe_n <= 1'b1;
    end else if (clk_en) begin
      case (st)
        SSF_IDLE: begin
          sck <= idle_lvl;
          sck_oe_n <= ~cfg.master;
          fss <= spi;
          fss_oe_n <= ~cfg.master;
          sdo_oe_n <= ~spi;
          half <= 1'b0;
          if (load_now) begin
            st <= spi ? SSF_LEAD : SSF_PULSE;
            fss <= ~spi;
            sck <= spi ? idle_lvl : 1'b1;
            sdo_oe_n <= 1'b0;
          end
        end
        SSF_PULSE: begin
          if (tick) begin
            if (!half) begin
              half <= 1'b1;
              sck <= 1'b0;
            end else begin
              st <= SSF_BITS;
              half <= 1'b0;
              fss <= 1'b0;
              sck <= 1'b1;
            end
          end
        end
        SSF_LEAD: begin
          if (tick) begin
            if (samp_lead && !half) begin
              half <= 1'b1;
            end else begin
              st <= SSF_BITS;
              half <= 1'b0;
              sck <= act_lvl;
            end
          end
        end
        SSF_BITS: begin
          if (tick) begin
            if (!half) begin
              half <= 1'b1;
              sck <= idle_lvl;
            end else if (last_bit) begin
              // Phase 0 sampled at the start of this period, so select may
              // rise now; otherwise one more half is still owed.
              st <= samp_lead ? SSF_HOLD : SSF_TAIL;
              fss <= samp_lead ? 1'b1 : fss;
            end else begin
              half <= 1'b0;
              sck <= act_lvl;
            end
          end
        end
        SSF_TAIL: begin
          if (tick) begin
            st <= SSF_HOLD;
          end
        end
        SSF_HOLD: begin
          half <= 1'b0;
          if (rxf_ready) begin
            if (go) begin
              if (!spi) begin
                st <= SSF_PULSE;
                fss <= 1'b1;
                sck <= 1'b1;
              end else if (cfg.clock_phase_bit) begin
                st <= SSF_LEAD;
              end else begin
                st <= SSF_GAP;
              end
            end else begin
              st <= SSF_IDLE;
              fss <= spi;
              sck <= idle_lvl;
              sdo_oe_n <= ~spi;
            end
          end
        end
        SSF_GAP: begin
          if (tick) begin
            st <= SSF_LEAD;
            fss <= 1'b0;
          end
        end
        default: begin
          st <= SSF_IDLE;
        end
      endcase
    end
  end

endmodule : ssf_frame_engine

// ---- verif/ssf_engine_props.sv ----
/*
  Pin timing checker of the frame engine, bound to its top module.
  Assumes configuration changes only while the engine is idle.
*/
`timescale 1ns/1ps
module ssf_engine_chk
  import ssf_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Watched ports
  input wire ssf_cfg_s cfg,
  input wire ssf_pins_s pins,
  input wire logic busy
);
  // ---------------------------------------------------------------------------
  // Ages of the last pin changes
  // ---------------------------------------------------------------------------
  logic sck_q;
  logic fss_q;
  logic [15:0] sck_age;
  logic [15:0] fss_age;
  logic [15:0] tog;
  logic [15:0] half;
  logic [15:0] bits;
  wire spi = cfg.format == SSF_FMT_SPI;
  wire m0 = spi && cfg.master && !cfg.clock_phase_bit;
  wire sck_ch = pins.serial_clock_pin != sck_q;
  wire fss_rise = pins.frame_select_pin && !fss_q;
  wire fss_fall = !pins.frame_select_pin && fss_q;
  assign half = {9'h0, (cfg.prescale_divisor[7:1] == 7'h0) ? 7'h1 : cfg.prescale_divisor[7:1]}
    * ({8'h0, cfg.clock_rate_field} + 16'h1);
  assign bits = (cfg.size_m1 < SSF_SIZE_MIN_M1) ? 16'h4 : {12'h0, cfg.size_m1} + 16'h1;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sck_q <= 1'b0;
      fss_q <= 1'b1;
      sck_age <= 16'h0;
      fss_age <= 16'h0;
      tog <= 16'h0;
    end else begin
      sck_q <= pins.serial_clock_pin;
      fss_q <= pins.frame_select_pin;
      sck_age <= sck_ch ? 16'h1 : sck_age + 16'h1;
      fss_age <= (fss_rise || fss_fall) ? 16'h1 : fss_age + 16'h1;
      tog <= pins.frame_select_pin ? 16'h0 : tog + {15'h0, sck_ch};
    end
  end
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_settled;
    !busy && $past(!busy) && $stable(cfg) && $past(rstn);
  endsequence
  property p_pulse_idle;
    (s_settled ##0 !spi) |-> !pins.serial_clock_pin && !pins.frame_select_pin
      && pins.serial_out_oe_n;
  endproperty
  a_pulse_idle: assert property (p_pulse_idle) else $error("pulsed idle pins wrong");
  property p_spi_idle;
    (s_settled ##0 spi) |-> pins.serial_clock_pin == cfg.clock_polarity_bit
      && pins.frame_select_pin && !pins.serial_out_pin;
  endproperty
  a_spi_idle: assert property (p_spi_idle) else $error("SPI idle pins wrong");
  property p_clk_drv;
    (s_settled ##0 spi) |-> pins.serial_clock_oe_n == !cfg.master;
  endproperty
  a_clk_drv: assert property (p_clk_drv) else $error("clock driver enable wrong");
  property p_start;
    $rose(busy) && spi && cfg.master |-> ##[0:1] !pins.frame_select_pin && !pins.serial_out_oe_n;
  endproperty
  a_start: assert property (p_start) else $error("transfer start pins wrong");
  property p_pulse_width;
    fss_fall && !spi && busy |-> fss_age == 16'h2 * half;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("frame pulse width wrong");
  property p_pulse_msb;
    fss_fall && !spi && busy |-> pins.serial_clock_pin && !pins.serial_out_oe_n;
  endproperty
  a_pulse_msb: assert property (p_pulse_msb) else $error("first bit not driven");
  property p_spi_edge;
    m0 && busy && sck_ch && !pins.frame_select_pin |-> sck_age == half || fss_age == 16'h2 * half;
  endproperty
  a_spi_edge: assert property (p_spi_edge) else $error("serial clock timing wrong");
  property p_word_gap;
    m0 && fss_rise && $past(busy) |-> tog == 16'h2 * bits;
  endproperty
  a_word_gap: assert property (p_word_gap) else $error("select not raised per word");
  property p_end;
    m0 && fss_rise && $past(busy) |-> sck_age == half;
  endproperty
  a_end: assert property (p_end) else $error("select release timing wrong");
endmodule : ssf_engine_chk

bind ssf_frame_engine ssf_engine_chk i_chk (.core_clk(core_clk), .rstn(rstn), .cfg(cfg),
  .pins(pins), .busy(busy));

// ---- verif/ssf_slave_model.sv ----
/*
  Behavioural external serial slave for the frame engine bench.
  Assumes the engine is link master and pins are seen once per core_clk edge.
*/
`timescale 1ns/1ps
module ssf_slave_model
  import ssf_pkg::*;
(
  // Clock and setup
  input wire logic core_clk,
  input wire ssf_cfg_s cfg,
  input wire logic [15:0] reply,
  // Link
  input wire ssf_pins_s pins,
  output logic serial_in_pin,
  // Captured words
  output logic [15:0] got,
  output logic got_stb
);
  logic sck_q = 1'b0;
  logic first = 1'b1;
  logic drv = 1'b0;
  logic [15:0] sh = 16'h0;
  logic [15:0] rcv = 16'h0;
  logic [4:0] cnt = 5'h0;
  logic [3:0] sz;
  assign sz = (cfg.size_m1 < SSF_SIZE_MIN_M1) ? SSF_SIZE_MIN_M1 : cfg.size_m1;
  wire spi = cfg.format == SSF_FMT_SPI;
  wire ch = pins.serial_clock_pin != sck_q;
  wire lead = ch && (sck_q == cfg.clock_polarity_bit);
  wire smp = spi ? (cfg.clock_phase_bit ? ch && !lead : lead) : ch && sck_q;
  wire chg = spi ? (cfg.clock_phase_bit ? lead : ch && !lead) : ch && sck_q == 1'b0;
  // A released line shows the inverse of the last bit so stale data never passes.
  assign serial_in_pin = (spi && pins.frame_select_pin) ? !drv : drv;
  always @(posedge core_clk) begin
    sck_q <= pins.serial_clock_pin;
    got_stb <= 1'b0;
    if (pins.frame_select_pin) begin
      first <= 1'b1;
      cnt <= 5'h0;
    end else if (first && ((spi && !cfg.clock_phase_bit) || chg)) begin
      sh <= reply << (4'hf - sz);
      drv <= reply[sz];
      first <= 1'b0;
    end else if (chg) begin
      sh <= sh << 1;
      drv <= sh[14];
    end
    if (smp && !pins.frame_select_pin) begin
      rcv <= {rcv[14:0], pins.serial_out_pin};
      cnt <= (cnt == {1'b0, sz}) ? 5'h0 : cnt + 5'h1;
      if (cnt == {1'b0, sz}) begin
        got <= {rcv[14:0], pins.serial_out_pin} & (16'hffff >> (4'hf - sz));
        got_stb <= 1'b1;
        first <= first || (spi && cfg.clock_phase_bit);
      end
    end
  end
endmodule : ssf_slave_model

// ---- verif/ssf_frame_engine_tb.sv ----
/*
  Self-checking bench of the frame engine against a behavioural slave.
  Assumes the checker is bound to the engine from its own file.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %0t got %h exp %h", $time, (g), (e)); end end
module ssf_frame_engine_tb;
  import ssf_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  ssf_cfg_s cfg = '0;
  logic tx_valid = 1'b0;
  logic tx_ready;
  logic [15:0] tx_data = 16'h0;
  logic rx_valid;
  logic rx_ready = 1'b0;
  logic [15:0] rx_data;
  ssf_pins_s pins;
  logic serial_in_pin;
  logic busy;
  logic [15:0] reply = 16'h0;
  logic [15:0] got;
  logic got_stb;
  logic stall = 1'b0;
  logic [15:0] mask;
  logic [15:0] exp_rx[$];
  logic [15:0] exp_sl[$];
  int error_cnt = 0;
  int checks_done = 0;
  int junk;
  assign mask = 16'hffff >> (4'hf - cfg.size_m1);
  ssf_frame_engine #(.FIFO_DEPTH(SSF_FIFO_DEPTH)) i_dut (.core_clk(core_clk), .rstn(rstn),
    .clk_en(clk_en), .cfg(cfg), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .pins(pins),
    .serial_in_pin(serial_in_pin), .busy(busy));
  ssf_slave_model i_slave (.core_clk(core_clk), .cfg(cfg), .reply(reply), .pins(pins),
    .serial_in_pin(serial_in_pin), .got(got), .got_stb(got_stb));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    rx_ready <= !stall && ($urandom_range(3) != 0);
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (exp_rx.size() == 0) error_cnt++;
      else `CHK(rx_data, exp_rx.pop_front())
    end
    if (got_stb === 1'b1) begin
      if (exp_sl.size() == 0) error_cnt++;
      else `CHK(got, exp_sl.pop_front())
    end
  end
  task automatic results;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  task automatic config_port(input logic f, p, h, m, input logic [3:0] sz);
    @(posedge core_clk);
    cfg.enable <= 1'b0;
    @(posedge core_clk);
    cfg <= '{1'b0, m, f, p, h, sz, 8'ha + 8'h2 * 8'($urandom_range(1)), 8'($urandom_range(1))};
    @(posedge core_clk);
    cfg.enable <= 1'b1;
  endtask : config_port
  task automatic burst(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      tx_valid <= 1'b1;
      tx_data <= 16'($urandom) & mask;
      k = 0;
      @(posedge core_clk);
      while (tx_ready !== 1'b1 && k < 5000) begin
        @(posedge core_clk);
        k++;
      end
      if (k >= 5000) error_cnt++;
      exp_sl.push_back(tx_data);
      exp_rx.push_back(reply & mask);
    end
    tx_valid <= 1'b0;
  endtask : burst
  task automatic wait_done;
    int n;
    n = 0;
    while ((exp_sl.size() + exp_rx.size() != 0 || busy !== 1'b0) && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 20000) error_cnt++;
  endtask : wait_done
  initial begin
    repeat (90000) @(posedge core_clk);
    error_cnt++;
    results();
  end
  initial begin
    junk = $urandom(32'h7a7e);
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      for (int m = 0; m < 5; m++) begin
        reply <= 16'($urandom);
        config_port(m != 0, m > 2, m == 2 || m == 4, 1'b1,
          (r == 0) ? 4'h3 : (r == 1) ? 4'hf : 4'($urandom_range(15, 3)));
        burst(3);
        wait_done();
      end
    end
    config_port(1'b1, 1'b0, 1'b0, 1'b0, 4'h7);
    burst(1);
    repeat (40) @(posedge core_clk);
    `CHK(busy, 1'b0)
    `CHK(pins.serial_clock_oe_n, 1'b1)
    `CHK(pins.frame_select_oe_n, 1'b1)
    config_port(1'b1, 1'b0, 1'b0, 1'b1, 4'h7);
    wait_done();
    `CHK(pins.frame_select_oe_n, 1'b0)
    stall <= 1'b1;
    config_port(1'b1, 1'b1, 1'b1, 1'b1, 4'h3);
    burst(33);
    repeat (300) @(posedge core_clk);
    `CHK(tx_ready, 1'b0)
    stall <= 1'b0;
    wait_done();
    clk_en <= 1'b0;
    tx_valid <= 1'b1;
    repeat (20) @(posedge core_clk);
    tx_valid <= 1'b0;
    clk_en <= 1'b1;
    repeat (20) @(posedge core_clk);
    `CHK(busy, 1'b0)
    `CHK(tx_ready, 1'b1)
    results();
  end
endmodule : ssf_frame_engine_tb
